// ==== verilog/hec_host_ep_ctrl.sv ====
// Module: host endpoint configuration, frame timers and auto packets
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
//
// Contract
// - Separate IN and OUT configuration per endpoint, recording direction and target speed.
// - Every configuration holds a transfer type: control, isochronous, bulk, interrupt.
// - Endpoint zero and bulk endpoints use the interval as a NAK timeout.
// - Interrupt endpoints poll every interval frames.
// - Isochronous endpoints poll every two to the power interval minus one frames.
// - As NAK timeout, interval n allows two to the n minus one frames.
// - A maximum encodable timeout exists, and one value disables the NAK limit.
// - Each endpoint carries a DMA access mode select field.
// - Auto transmit starts an OUT packet once max payload bytes sit in FIFO.
// - Auto request issues the next IN once FIFO has room for max payload.
// - Auto clear drops receive-ready once the packet has been read out.
// - A data acknowledge command marks the received packet as consumed.
// - Software forces the data toggle: zero gives DATA0, one gives DATA1.
// - Endpoint zero ignores the direction select; it has one shared toggle.
// - Status clear clears exactly the written bits, same layout as status read.
// - A readable, writable hub address is held per endpoint and direction.
// - Remote endpoint number and max payload are held per host endpoint.
// - A control switches the controller into host role, enabling endpoint logic.
// - Target function address is held per endpoint and direction.
module hec_host_ep_ctrl
   import hec_pkg::*;
#(
   parameter int NUM_EP = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_tick,
   input wire logic [NUM_EP-1:0] nak_in,
   input wire logic [NUM_EP-1:0] nak_out,
   input wire logic [NUM_EP-1:0] xfer_ok_in,
   input wire logic [NUM_EP-1:0] xfer_ok_out,
   input wire logic [NUM_EP-1:0] rx_packet,
   input wire logic [NUM_EP-1:0] rx_read_done,
   input wire logic [NUM_EP-1:0][10:0] tx_fifo_bytes,
   input wire logic [NUM_EP-1:0][10:0] rx_fifo_space,
   output logic host_mode,
   output logic [NUM_EP-1:0] tx_start,
   output logic [NUM_EP-1:0] in_request,
   output logic [NUM_EP-1:0] poll_in,
   output logic [NUM_EP-1:0] poll_out,
   output logic [NUM_EP-1:0] toggle_in,
   output logic [NUM_EP-1:0] toggle_out,
   output logic [NUM_EP-1:0] rx_ready,
   output logic [NUM_EP-1:0] timeout_in,
   output logic [NUM_EP-1:0] timeout_out
);

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      logic host_mode;
      hec_ep_s [NUM_EP-1:0] ep;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [NUM_EP-1:0] tx_start;
      logic [NUM_EP-1:0] in_request;
      logic [NUM_EP-1:0] poll_in;
      logic [NUM_EP-1:0] poll_out;
   } hec_state_s;

   hec_state_s st_ff;
   hec_state_s nxt_st;

   // ********************************************************************
   // Helpers
   // ********************************************************************

   // Frames per period: linear or power of two
   function automatic logic [16:0] hec_period(input logic linear, input logic [7:0] n);
      logic [4:0] e;
      begin
         e = (n > HEC_MAX_NAK_LIMIT) ? HEC_MAX_NAK_LIMIT[4:0] : n[4:0];
         if (n == HEC_DISABLE_NAK_LIMIT) begin
            hec_period = 17'h00001;
         end else if (linear) begin
            hec_period = {9'h000, n};
         end else begin
            hec_period = 17'h00001 << (e - 5'h01);
         end
      end
   endfunction

   // Configuration word as software reads it
   function automatic logic [31:0] hec_cfg_word(input hec_cfg_s c, input logic dir);
      hec_cfg_word = {c.remote_endpoint_number, 1'b0, c.max_payload_size, c.interval_setting,
         dir, c.auto_ready_clear, c.auto_move, c.dma_access_select, c.target_low_speed,
         c.ep_type};
   endfunction

   function automatic hec_cfg_s hec_cfg_load(input hec_cfg_s c, input logic [31:0] w);
      hec_cfg_s r;
      begin
         r = c;
         r.ep_type = hec_type_e'(w[1:0]);
         r.target_low_speed = w[2];
         r.dma_access_select = w[4:3];
         r.auto_move = w[5];
         r.auto_ready_clear = w[6];
         r.interval_setting = w[15:8];
         r.max_payload_size = w[26:16];
         r.remote_endpoint_number = w[31:28];
         hec_cfg_load = r;
      end
   endfunction

   // Frame timer of one direction
   function automatic hec_dir_s hec_dir_step(input hec_dir_s d, input logic ep0,
      input logic run, input logic nak, input logic ok, output logic poll);
      hec_dir_s r;
      logic nak_mode;
      logic [16:0] per;
      logic [16:0] cnt1;
      begin
         r = d;
         poll = 1'b0;
         nak_mode = ep0 || (d.cfg.ep_type == type_bulk) || (d.cfg.ep_type == type_control);
         per = hec_period(d.cfg.ep_type == type_interrupt, d.cfg.interval_setting);
         cnt1 = {1'b0, d.frame_cnt} + 17'h00001;
         if (!run) begin
            r.frame_cnt = 16'h0000;
            r.nak_active = 1'b0;
         end else if (nak_mode) begin
            if (ok) begin
               r.nak_active = 1'b0;
               r.frame_cnt = 16'h0000;
            end else if (nak && !d.nak_active &&
               d.cfg.interval_setting != HEC_DISABLE_NAK_LIMIT) begin
               r.nak_active = 1'b1;
               r.frame_cnt = 16'h0000;
            end else if (d.nak_active && frame_tick) begin
               if (cnt1 >= per) begin
                  r.timeout = 1'b1;
                  r.nak_active = 1'b0;
                  r.frame_cnt = 16'h0000;
               end else begin
                  r.frame_cnt = cnt1[15:0];
               end
            end
         end else if (frame_tick) begin
            // Polling period restarts after each poll
            if (cnt1 >= per) begin
               poll = 1'b1;
               r.frame_cnt = 16'h0000;
            end else begin
               r.frame_cnt = cnt1[15:0];
            end
         end
         if (ok) begin
            r.toggle = ~r.toggle;
         end
         hec_dir_step = r;
      end
   endfunction

   // ********************************************************************
   // Next-state logic
   // ********************************************************************
   logic setup;
   logic access;
   logic ctrl_hit;
   logic bank_hit;
   logic [2:0] sel_ep;
   logic [4:0] sel_ofs;
   logic reg_hit;
   logic [31:0] rd_word;

   // Address decode; paddr holds through both phases
   always_comb begin
      sel_ep = paddr[7:HEC_EP_STRIDE_LSB];
      sel_ofs = paddr[HEC_EP_STRIDE_LSB-1:0];
      ctrl_hit = (paddr == HEC_CTRL_OFS);
      bank_hit = (paddr[11:8] == HEC_EP_BANK_HI) && (32'(sel_ep) < NUM_EP) &&
         (sel_ofs <= HEC_CMD_OFS) && (sel_ofs[1:0] == 2'h0);
      reg_hit = ctrl_hit || bank_hit;
      setup = psel && !penable && !st_ff.pready;
      access = psel && penable && st_ff.pready;
   end

   // Read mux; command and clear words read zero
   always_comb begin
      hec_ep_s e;
      e = HEC_EP_RST;
      rd_word = 32'h00000000;
      if (bank_hit) begin
         e = st_ff.ep[sel_ep];
      end
      if (ctrl_hit) begin
         rd_word = {31'h00000000, st_ff.host_mode};
      end else if (bank_hit) begin
         case (sel_ofs)
            HEC_IN_CFG_OFS: rd_word = hec_cfg_word(e.dir_in.cfg, host_dir_in);
            HEC_OUT_CFG_OFS: rd_word = hec_cfg_word(e.dir_out.cfg, host_dir_out);
            HEC_IN_ADDR_OFS: rd_word = {17'h00000, e.dir_in.cfg.hub_addr, 1'b0,
               e.dir_in.cfg.func_addr};
            HEC_OUT_ADDR_OFS: rd_word = {17'h00000, e.dir_out.cfg.hub_addr, 1'b0,
               e.dir_out.cfg.func_addr};
            HEC_STATUS_OFS: begin
               rd_word[HEC_ST_RX_READY] = e.rx_ready;
               rd_word[HEC_ST_IN_TIMEOUT] = e.dir_in.timeout;
               rd_word[HEC_ST_OUT_TIMEOUT] = e.dir_out.timeout;
               rd_word[HEC_ST_TX_BUSY] = e.tx_busy;
               rd_word[HEC_ST_REQ_PEND] = e.req_pending;
               rd_word[HEC_ST_TOGGLE_IN] = e.dir_in.toggle;
               rd_word[HEC_ST_TOGGLE_OUT] = e.dir_out.toggle;
            end
            default: rd_word = 32'h00000000;
         endcase
      end
   end

   // Software first, hardware events after: an event wins over a clear
   always_comb begin
      logic wr;
      logic [31:0] clr;
      logic p_in;
      logic p_out;
      logic run;
      hec_ep_s e;
      nxt_st = st_ff;
      wr = access && pwrite && reg_hit;
      clr = 32'h00000000;
      p_in = 1'b0;
      p_out = 1'b0;
      run = 1'b0;
      e = HEC_EP_RST;
      nxt_st.tx_start = '0;
      nxt_st.in_request = '0;
      nxt_st.poll_in = '0;
      nxt_st.poll_out = '0;

      // APB: answer registered in setup, no wait state
      nxt_st.pready = setup;
      nxt_st.pslverr = setup && !reg_hit;
      if (setup) begin
         nxt_st.prdata = (pwrite || !reg_hit) ? 32'h00000000 : rd_word;
      end

      if (wr && ctrl_hit) begin
         nxt_st.host_mode = pwdata[0];
      end
      run = nxt_st.host_mode;

      for (int i = 0; i < NUM_EP; i++) begin
         e = nxt_st.ep[i];
         clr = 32'h00000000;
         if (wr && bank_hit && 32'(sel_ep) == i) begin
            case (sel_ofs)
               HEC_IN_CFG_OFS: e.dir_in.cfg = hec_cfg_load(e.dir_in.cfg, pwdata);
               HEC_OUT_CFG_OFS: e.dir_out.cfg = hec_cfg_load(e.dir_out.cfg, pwdata);
               HEC_IN_ADDR_OFS: begin
                  e.dir_in.cfg.func_addr = pwdata[6:0];
                  e.dir_in.cfg.hub_addr = pwdata[14:8];
               end
               HEC_OUT_ADDR_OFS: begin
                  e.dir_out.cfg.func_addr = pwdata[6:0];
                  e.dir_out.cfg.hub_addr = pwdata[14:8];
               end
               HEC_STAT_CLR_OFS: clr = pwdata;
               HEC_CMD_OFS: begin
                  if (pwdata[HEC_CMD_DATA_ACK]) begin
                     e.rx_ready = 1'b0;
                  end
                  if (pwdata[HEC_CMD_FORCE_TOGGLE]) begin
                     // One toggle at endpoint zero
                     if (i == 0 || !pwdata[HEC_CMD_DIR_OUT]) begin
                        e.dir_in.toggle = pwdata[HEC_CMD_TOGGLE_VALUE];
                     end else begin
                        e.dir_out.toggle = pwdata[HEC_CMD_TOGGLE_VALUE];
                     end
                  end
               end
               default: e = nxt_st.ep[i];
            endcase
         end

         // Clear exactly the written bits
         if (clr[HEC_ST_RX_READY]) begin
            e.rx_ready = 1'b0;
         end
         if (clr[HEC_ST_IN_TIMEOUT]) begin
            e.dir_in.timeout = 1'b0;
         end
         if (clr[HEC_ST_OUT_TIMEOUT]) begin
            e.dir_out.timeout = 1'b0;
         end
         if (clr[HEC_ST_TX_BUSY]) begin
            e.tx_busy = 1'b0;
         end
         if (clr[HEC_ST_REQ_PEND]) begin
            e.req_pending = 1'b0;
         end

         // Frame timers; endpoint zero always times NAKs
         e.dir_in = hec_dir_step(e.dir_in, i == 0, run, nak_in[i], xfer_ok_in[i], p_in);
         e.dir_out = hec_dir_step(e.dir_out, i == 0, run, nak_out[i], xfer_ok_out[i], p_out);
         if (i == 0) begin
            // Shared toggle: a success in one direction flips it; successes in both in one cycle cancel
            e.dir_in.toggle = nxt_st.ep[i].dir_in.toggle ^ (xfer_ok_in[i] ^ xfer_ok_out[i]);
            if (wr && bank_hit && 32'(sel_ep) == i && sel_ofs == HEC_CMD_OFS &&
               pwdata[HEC_CMD_FORCE_TOGGLE]) begin
               e.dir_in.toggle = pwdata[HEC_CMD_TOGGLE_VALUE];
            end
            e.dir_out.toggle = e.dir_in.toggle;
         end
         nxt_st.poll_in[i] = p_in;
         nxt_st.poll_out[i] = p_out;

         // Auto clear frees the packet without software
         if (rx_read_done[i] && e.dir_in.cfg.auto_ready_clear) begin
            e.rx_ready = 1'b0;
         end
         if (xfer_ok_out[i]) begin
            e.tx_busy = 1'b0;
         end
         if (rx_packet[i]) begin
            e.rx_ready = 1'b1;
            e.req_pending = 1'b0;
         end

         // One OUT packet in flight at a time
         if (run && e.dir_out.cfg.auto_move && !e.tx_busy &&
            e.dir_out.cfg.max_payload_size != 11'h000 &&
            tx_fifo_bytes[i] >= e.dir_out.cfg.max_payload_size) begin
            e.tx_busy = 1'b1;
            nxt_st.tx_start[i] = 1'b1;
         end

         // Wait for room so an IN answer cannot overrun the FIFO
         if (run && e.dir_in.cfg.auto_move && !e.rx_ready && !e.req_pending &&
            rx_fifo_space[i] >= e.dir_in.cfg.max_payload_size) begin
            e.req_pending = 1'b1;
            nxt_st.in_request[i] = 1'b1;
         end
         nxt_st.ep[i] = e;
      end
   end

   // ********************************************************************
   // Registers
   // ********************************************************************

   // Synchronous reset clears all state, host role off
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign host_mode = st_ff.host_mode;
   assign tx_start = st_ff.tx_start;
   assign in_request = st_ff.in_request;
   assign poll_in = st_ff.poll_in;
   assign poll_out = st_ff.poll_out;

   // Per-endpoint status flops
   for (genvar g = 0; g < NUM_EP; g++) begin : g_ep_out
      assign toggle_in[g] = st_ff.ep[g].dir_in.toggle;
      assign toggle_out[g] = st_ff.ep[g].dir_out.toggle;
      assign rx_ready[g] = st_ff.ep[g].rx_ready;
      assign timeout_in[g] = st_ff.ep[g].dir_in.timeout;
      assign timeout_out[g] = st_ff.ep[g].dir_out.timeout;
   end

endmodule

// ==== verilog/hec_pkg.sv ====
// Package: constants and types of the host endpoint controller
package hec_pkg;

   // ********************************************************************
   // Register map (byte addresses, 32-bit aligned words)
   // ********************************************************************
   localparam logic [11:0] HEC_CTRL_OFS = 12'h000;     // Global role control
   localparam logic [3:0] HEC_EP_BANK_HI = 4'h1;       // Endpoint banks live at 0x100..0x1FF
   localparam int HEC_EP_STRIDE_LSB = 5;               // 0x20 bytes per endpoint bank
   localparam logic [4:0] HEC_IN_CFG_OFS = 5'h00;
   localparam logic [4:0] HEC_IN_ADDR_OFS = 5'h04;
   localparam logic [4:0] HEC_OUT_CFG_OFS = 5'h08;
   localparam logic [4:0] HEC_OUT_ADDR_OFS = 5'h0C;
   localparam logic [4:0] HEC_STATUS_OFS = 5'h10;
   localparam logic [4:0] HEC_STAT_CLR_OFS = 5'h14;
   localparam logic [4:0] HEC_CMD_OFS = 5'h18;

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int HEC_ST_RX_READY = 0;
   localparam int HEC_ST_IN_TIMEOUT = 1;
   localparam int HEC_ST_OUT_TIMEOUT = 2;
   localparam int HEC_ST_TX_BUSY = 3;
   localparam int HEC_ST_REQ_PEND = 4;
   localparam int HEC_ST_TOGGLE_IN = 8;
   localparam int HEC_ST_TOGGLE_OUT = 9;
   localparam int HEC_CMD_DATA_ACK = 0;
   localparam int HEC_CMD_FORCE_TOGGLE = 1;
   localparam int HEC_CMD_TOGGLE_VALUE = 2;
   localparam int HEC_CMD_DIR_OUT = 3;
   localparam logic host_dir_in = 1'b0;
   localparam logic host_dir_out = 1'b1;

   // ********************************************************************
   // Interval encoding
   // ********************************************************************
   localparam logic [7:0] HEC_DISABLE_NAK_LIMIT = 8'h00;   // No NAK timeout at all
   localparam logic [7:0] HEC_MAX_NAK_LIMIT = 8'h10;       // Largest encodable exponent

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {
      type_control = 2'h0,
      type_isochronous = 2'h1,
      type_bulk = 2'h2,
      type_interrupt = 2'h3
   } hec_type_e;

   typedef struct packed {
      hec_type_e ep_type;
      logic target_low_speed;          // 0 means target_full_speed
      logic [1:0] dma_access_select;
      logic auto_move;                 // auto_transmit (OUT) or auto_in_request (IN)
      logic auto_ready_clear;          // IN only
      logic [7:0] interval_setting;
      logic [10:0] max_payload_size;
      logic [3:0] remote_endpoint_number;
      logic [6:0] func_addr;
      logic [6:0] hub_addr;
   } hec_cfg_s;

   typedef struct packed {
      hec_cfg_s cfg;
      logic [15:0] frame_cnt;
      logic nak_active;
      logic timeout;
      logic toggle;
   } hec_dir_s;

   typedef struct packed {
      hec_dir_s dir_in;
      hec_dir_s dir_out;
      logic rx_ready;
      logic tx_busy;
      logic req_pending;
   } hec_ep_s;

   localparam hec_ep_s HEC_EP_RST = '0;

endpackage

// ==== verification/hec_host_ep_ctrl_asserts.sv ====
// Checker: port properties of the host endpoint controller
`timescale 1ns/100ps
module hec_host_ep_ctrl_asserts
   import hec_pkg::*;
#(
   parameter int NUM_EP = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_tick,
   input wire logic [NUM_EP-1:0] rx_read_done,
   input wire logic host_mode,
   input wire logic [NUM_EP-1:0] tx_start,
   input wire logic [NUM_EP-1:0] poll_in,
   input wire logic [NUM_EP-1:0] poll_out,
   input wire logic [NUM_EP-1:0] toggle_in,
   input wire logic [NUM_EP-1:0] toggle_out,
   input wire logic [NUM_EP-1:0] rx_ready,
   input wire logic [NUM_EP-1:0] timeout_in
);
   // ****
   // Helpers
   // ****
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic wr_acc;
   // Completed write: the only way software clears
   assign wr_acc = psel && penable && pready && pwrite;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   // ****
   // Properties
   // ****
   a_apb_answer: assert property (s_setup |=> s_answer)
      else $error("pready not one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_ep0_shared: assert property (toggle_out[0] == toggle_in[0])
      else $error("ep0 toggles differ");
   a_ready_fall: assert property (|($past(rx_ready) & ~rx_ready)
      |-> $past(wr_acc || (|rx_read_done))) else $error("rx_ready fell uncaused");
   a_to_clear: assert property (|($past(timeout_in) & ~timeout_in)
      |-> $past(wr_acc && paddr[4:0] == HEC_STAT_CLR_OFS))
      else $error("timeout fell uncleared");
   a_to_tick: assert property (|(~$past(timeout_in) & timeout_in) |-> $past(frame_tick))
      else $error("timeout rose off a frame");
   a_poll_tick: assert property (|{poll_in, poll_out} |-> $past(frame_tick))
      else $error("poll off a frame");
   a_tx_once: assert property ((tx_start & $past(tx_start)) == '0)
      else $error("tx_start held two cycles");
   a_role_gate: assert property (!host_mode && !$past(host_mode)
      |-> tx_start == '0 && poll_in == '0) else $error("active outside host");
endmodule

// ==== verification/hec_usb_dev_model.sv ====
// Partner model: attached device with quick or slow answers
`timescale 1ns/100ps
module hec_usb_dev_model #(
   parameter int NUM_EP = 4,
   parameter int FRAME_CYC = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   input wire logic [NUM_EP-1:0] tx_start,
   input wire logic [NUM_EP-1:0] in_request,
   output logic frame_tick,
   output logic [NUM_EP-1:0] xfer_ok_in,
   output logic [NUM_EP-1:0] xfer_ok_out,
   output logic [NUM_EP-1:0] rx_packet
);
   int frm_ff;
   logic [5:0][NUM_EP-1:0] in_sr_ff, out_sr_ff;
   // Free-running frames; slow must change only when idle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         frm_ff <= 0;
         in_sr_ff <= '0;
         out_sr_ff <= '0;
      end else begin
         frm_ff <= (frm_ff == FRAME_CYC - 1) ? 0 : frm_ff + 1;
         in_sr_ff <= {in_sr_ff[4:0], in_request};
         out_sr_ff <= {out_sr_ff[4:0], tx_start};
      end
   end
   // Each request gets an answer
   assign frame_tick = (frm_ff == FRAME_CYC - 1);
   assign rx_packet = slow ? in_sr_ff[5] : in_sr_ff[0];
   assign xfer_ok_in = rx_packet;
   assign xfer_ok_out = slow ? out_sr_ff[5] : out_sr_ff[0];
endmodule

// ==== verification/tb.sv ====
// Testbench: registers, frame timers, auto packets and toggles
`timescale 1ns/100ps
module tb;
   import hec_pkg::*;
   localparam int NUM_EP = 4;
   // ****
   // Signals
   // ****
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic slow = 1'b1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, frame_tick, host_mode;
   logic [NUM_EP-1:0] nak_in = '0, nak_out = '0, rx_read_done = '0;
   logic [NUM_EP-1:0] xfer_ok_in, xfer_ok_out, rx_packet, tx_start, in_request;
   logic [NUM_EP-1:0] poll_in, poll_out, toggle_in, toggle_out, rx_ready, timeout_in, timeout_out;
   logic [NUM_EP-1:0][10:0] tx_fifo_bytes = '0, rx_fifo_space = '0;
   logic [5*NUM_EP-1:0] mon;
   int failures = 0, total_checks = 0, cyc = 0, tx_cnt = 0, in_cnt = 0;
   assign mon = {poll_in, rx_ready, tx_start, poll_out, timeout_in};
   hec_host_ep_ctrl #(.NUM_EP(NUM_EP)) u_hec_host_ep_ctrl (.*);
   hec_usb_dev_model #(.NUM_EP(NUM_EP), .FRAME_CYC(8)) u_hec_usb_dev_model (.*);
   // Clock of 4 ns
   always #2 clk_sys = ~clk_sys;
   // Hang guard and pulse counters on endpoint one
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      tx_cnt <= tx_cnt + int'(tx_start[1]);
      in_cnt <= in_cnt + int'(in_request[1]);
      if (cyc == 50000) begin
         failures++;
         report_and_stop();
      end
   end
   // ****
   // Tasks
   // ****
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer, released after pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
         input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(what, exp, q & m);
   endtask
   function automatic logic [11:0] ea(input int ep, input logic [4:0] ofs);
      return {HEC_EP_BANK_HI, 3'(ep), ofs};
   endfunction
   // Frames counted until a watched bit goes high
   task automatic ticks_until(input int b, output int cnt);
      cnt = 0;
      while (mon[b] !== 1'b1) begin
         @(posedge clk_sys);
         cnt += int'(frame_tick);
      end
   endtask
   task automatic period(input int b, input int p);
      int c;
      ticks_until(b, c);
      @(posedge clk_sys);
      ticks_until(b, c);
      chk("poll period", p, c);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      rd_chk("out cfg rst", ea(2, HEC_OUT_CFG_OFS), '1, 32'h0000_0080);
      for (int t = 0; t < 4; t++) begin
         wr(ea(t, HEC_IN_CFG_OFS), 32'hFFFF_FFFC | 32'(t));
         rd_chk("in cfg", ea(t, HEC_IN_CFG_OFS), '1, 32'hF7FF_FF7C | 32'(t));
      end
      wr(ea(3, HEC_OUT_ADDR_OFS), 32'hFFFF_FFFF);
      rd_chk("out addr", ea(3, HEC_OUT_ADDR_OFS), '1, 32'h0000_7F7F);
      rd_chk("in addr", ea(3, HEC_IN_ADDR_OFS), '1, 32'h0000_0000);
      apb(1'b0, 12'h0F0, 32'h0000_0000, q, e);
      chk("unmapped", 32'h0000_0001, {q[30:0], e});
      wr(HEC_CTRL_OFS, 32'h0000_0001);
      @(posedge clk_sys);
      chk("host mode", 32'h0000_0001, 32'(host_mode));
   endtask
   task automatic t_nak();
      int c;
      wr(ea(1, HEC_IN_CFG_OFS), 32'h0000_0302);
      wr(ea(2, HEC_IN_CFG_OFS), 32'h0000_0002);
      wr(ea(0, HEC_OUT_CFG_OFS), 32'h0000_0100);
      // NAK just after a frame start
      do @(posedge clk_sys); while (frame_tick !== 1'b1);
      nak_in <= 4'h6;
      nak_out <= 4'h1;
      @(posedge clk_sys);
      nak_in <= '0;
      nak_out <= '0;
      ticks_until(1, c);
      chk("nak frames", 4, c);
      chk("ep0 timeout", 32'h1, 32'(timeout_out[0]));
      chk("no limit", 32'h0, 32'(timeout_in[2]));
      wr(ea(1, HEC_STAT_CLR_OFS), 32'h0000_0002);
      rd_chk("status clr", ea(1, HEC_STATUS_OFS), 32'h0000_0002, 32'h0);
      wr(ea(0, HEC_STAT_CLR_OFS), 32'h0000_0001);
      @(posedge clk_sys);
      chk("other bit", 32'h1, 32'(timeout_out[0]));
   endtask
   task automatic t_poll();
      wr(ea(1, HEC_OUT_CFG_OFS), 32'h0000_0303);
      wr(ea(2, HEC_OUT_CFG_OFS), 32'h0000_0301);
      wr(ea(2, HEC_IN_CFG_OFS), 32'h0000_0203);
      period(NUM_EP + 1, 3);
      period(NUM_EP + 2, 4);
      period(4 * NUM_EP + 2, 2);
   endtask
   task automatic pkt(input logic [10:0] s);
      int c;
      rx_fifo_space[1] <= s;
      ticks_until(3 * NUM_EP + 1, c);
      rx_fifo_space[1] <= 11'h000;
      rx_read_done[1] <= 1'b1;
      @(posedge clk_sys);
      rx_read_done[1] <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_auto();
      int c;
      wr(ea(1, HEC_OUT_CFG_OFS), 32'h0008_0022);
      tx_fifo_bytes[1] <= 11'h007;
      repeat (12) @(posedge clk_sys);
      chk("tx short", 0, tx_cnt);
      tx_fifo_bytes[1] <= 11'h008;
      ticks_until(2 * NUM_EP + 1, c);
      tx_fifo_bytes[1] <= 11'h000;
      repeat (12) @(posedge clk_sys);
      chk("tx once", 1, tx_cnt);
      rd_chk("tx done", ea(1, HEC_STATUS_OFS), 32'h0000_0008, 32'h0);
      slow <= 1'b0;
      wr(ea(1, HEC_IN_CFG_OFS), 32'h0008_0062);
      rx_fifo_space[1] <= 11'h007;
      repeat (12) @(posedge clk_sys);
      chk("in short", 0, in_cnt);
      pkt(11'h008);
      chk("in once", 1, in_cnt);
      chk("auto clear", 32'h0, 32'(rx_ready[1]));
      wr(ea(1, HEC_IN_CFG_OFS), 32'h0008_0022);
      pkt(11'h008);
      chk("kept ready", 32'h1, 32'(rx_ready[1]));
      wr(ea(1, HEC_CMD_OFS), 32'h0000_0001);
      @(posedge clk_sys);
      chk("data ack", 32'h0, 32'(rx_ready[1]));
      pkt(11'h008);
      wr(ea(1, HEC_STAT_CLR_OFS), 32'h0000_0001);
      @(posedge clk_sys);
      chk("sw clear", 32'h0, 32'(rx_ready[1]));
   endtask
   task automatic t_toggle();
      wr(ea(2, HEC_CMD_OFS), 32'h0000_0006);
      wr(ea(2, HEC_CMD_OFS), 32'h0000_000E);
      wr(ea(2, HEC_CMD_OFS), 32'h0000_000A);
      rd_chk("toggles", ea(2, HEC_STATUS_OFS), 32'h0000_0300, 32'h0000_0100);
      wr(ea(0, HEC_CMD_OFS), 32'h0000_000E);
      @(posedge clk_sys);
      chk("ep0 shared", 32'h3, 32'({toggle_out[0], toggle_in[0]}));
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reset for two cycles, then the scenarios
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_nak();
      t_poll();
      t_auto();
      t_toggle();
      report_and_stop();
   end
endmodule
bind hec_host_ep_ctrl hec_host_ep_ctrl_asserts #(.NUM_EP(NUM_EP)) u_chk (.*);
